// [gpb_bank.sv]
// Pin configuration bank for eight pads, with an AXI4-Lite register slave.
//
// Operation
// - Bit 0 set makes the pin an input, clear makes it an output.
// - Bit 1 set inverts the pin value, clear passes it unchanged.
// - Bit 7 set gives an open-drain driver, clear a push-pull driver.
// - Index 0x31 sets pin 2.6; bit 2 routes music serial output; resets 0x01.
// - Index 0x32 sets pin 2.7; bit 2 drives the active-low management interrupt.
// - Index 0x33 sets pin 3.0; bit 2 feeds the second fan speed sense.
// - Index 0x34 sets pin 3.1; bit 2 feeds the first fan speed sense.
// - Index 0x35 sets pin 3.2; bit 2 drives the second fan drive output.
// - Pins 3.2 and 3.3 reset 0x01 on standby, 0x00 on main reset.
// - Index 0x36 sets pin 3.3; bit 2 clear is plain GPIO.
// - Index 0x37 sets pin 3.4; bit 2 feeds infrared receive; resets 0x05.
// - Index 0x38 sets pin 3.5; bit 2 drives infrared transmit; resets 0x04.
`timescale 1ns/1ps
module gpb_bank #(
  parameter int ADDR_W = gpb_pkg::ADDR_W
) (
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  input  wire logic                            main_rst,
  input  wire logic                            clk_en,
  input  wire logic [ADDR_W-1:0]               s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [31:0]                     s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [ADDR_W-1:0]               s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [31:0]                          s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic [gpb_pkg::NUM_PINS-1:0]    pad_in,
  output logic      [gpb_pkg::NUM_PINS-1:0]    pad_out,
  output logic      [gpb_pkg::NUM_PINS-1:0]    pad_oe,
  input  wire logic [gpb_pkg::NUM_PINS-1:0]    gpio_out_value,
  output logic      [gpb_pkg::NUM_PINS-1:0]    gpio_in_value,
  input  wire logic                            music_serial_output,
  input  wire logic                            system_mgmt_interrupt_out_n,
  input  wire logic                            fan_drive_b,
  input  wire logic                            infrared_transmit_b,
  output logic                                 fan_speed_sense_a,
  output logic                                 fan_speed_sense_b,
  output logic                                 infrared_receive_b
);

  localparam int NP = gpb_pkg::NUM_PINS;

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  logic [NP-1:0][7:0]   cfg_ff;
  logic [ADDR_W-1:0]    aw_addr_ff;
  logic                 aw_held_ff;
  logic [7:0]           w_data_ff;
  logic                 w_lane0_ff;
  logic                 w_held_ff;
  logic                 bvalid_ff;
  logic [1:0]           bresp_ff;
  logic                 rvalid_ff;
  logic [1:0]           rresp_ff;
  logic [31:0]          rdata_ff;
  logic                 wr_fire;
  logic [NP-1:0]        wr_hit;
  logic                 wr_mapped;
  logic [gpb_pkg::IDX_W-1:0] wr_idx;
  logic [gpb_pkg::IDX_W-1:0] rd_idx;
  logic                 rd_mapped;
  logic [7:0]           rd_byte;
  logic [NP-1:0]        alt_value;
  logic [NP-1:0]        alt_in;

  // ---------------------------------------------------------------------
  // Write channel
  // ---------------------------------------------------------------------
  // Address and data are caught independently, in either order, and the
  // write takes effect once both are held and no response is pending.
  assign s_axi_awready = !aw_held_ff;
  assign s_axi_wready  = !w_held_ff;
  assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff && clk_en;
  assign wr_idx        = aw_addr_ff[gpb_pkg::IDX_LSB +: gpb_pkg::IDX_W];
  assign wr_mapped     = (wr_idx >= gpb_pkg::IDX_FIRST) && (wr_idx <= gpb_pkg::IDX_LAST);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= '0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      w_held_ff  <= 1'b0;
      w_data_ff  <= 8'h00;
      w_lane0_ff <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff  <= 1'b1;
        w_data_ff  <= s_axi_wdata[7:0];
        w_lane0_ff <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= gpb_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_mapped ? gpb_pkg::RESP_OKAY : gpb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // ---------------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------------
  // Both resets act whatever the clock enable does, so a frozen bank still
  // comes up in a known state; the standby reset wins over the main one.
  for (genvar i = 0; i < NP; i++) begin : g_cfg
    assign wr_hit[i] = wr_fire && w_lane0_ff &&
                       (wr_idx == gpb_pkg::IDX_FIRST + 8'(i));

    always_ff @(posedge core_clk) begin
      if (rst) begin
        cfg_ff[i] <= gpb_pkg::STBY_RST_VAL[i];
      end else if (main_rst && gpb_pkg::MAIN_RST_HIT[i]) begin
        cfg_ff[i] <= gpb_pkg::MAIN_RST_VAL[i];
      end else if (wr_hit[i]) begin
        cfg_ff[i] <= w_data_ff & gpb_pkg::CFG_WRITE_MASK;
      end
    end

    gpb_pin_cell #(
      .ALT_KIND   (gpb_pkg::ALT_KIND[i])
    ) u_cell (
      .core_clk   (core_clk),
      .rst        (rst),
      .clk_en     (clk_en),
      .cfg        (cfg_ff[i]),
      .gpio_value (gpio_out_value[i]),
      .alt_value  (alt_value[i]),
      .pad_in     (pad_in[i]),
      .pad_out    (pad_out[i]),
      .pad_oe     (pad_oe[i]),
      .gpio_in    (gpio_in_value[i]),
      .alt_in     (alt_in[i])
    );
  end

  // ---------------------------------------------------------------------
  // Alternate function routing
  // ---------------------------------------------------------------------
  // Input slots carry no driven value; the cell ignores them.
  assign alt_value = {infrared_transmit_b, 1'b0, 1'b0, fan_drive_b,
                      1'b0, 1'b0, system_mgmt_interrupt_out_n,
                      music_serial_output};
  assign fan_speed_sense_b  = alt_in[2];
  assign fan_speed_sense_a  = alt_in[3];
  assign infrared_receive_b = alt_in[6];

  // ---------------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign rd_idx        = s_axi_araddr[gpb_pkg::IDX_LSB +: gpb_pkg::IDX_W];
  assign rd_mapped     = (rd_idx >= gpb_pkg::IDX_FIRST) && (rd_idx <= gpb_pkg::IDX_LAST);

  always_comb begin
    rd_byte = 8'h00;
    for (int k = 0; k < NP; k++) begin
      if (rd_idx == gpb_pkg::IDX_FIRST + 8'(k)) begin
        rd_byte = cfg_ff[k];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= gpb_pkg::RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= rd_mapped ? gpb_pkg::RESP_OKAY : gpb_pkg::RESP_SLVERR;
        rdata_ff  <= {24'h00_0000, rd_byte};
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp  = rresp_ff;
  assign s_axi_rdata  = rdata_ff;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  rsv_bits_zero_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (cfg_ff[0][6:3] | cfg_ff[1][6:3] | cfg_ff[2][6:3] | cfg_ff[3][6:3] |
     cfg_ff[4][6:3] | cfg_ff[5][6:3] | cfg_ff[6][6:3] | cfg_ff[7][6:3]) == 4'h0)
    else $error("Reserved configuration bits are not zero.");

  stby_reset_vals_a: assert property (
    @(posedge core_clk) disable iff (rst)
    $fell(rst) |-> (cfg_ff[0] == 8'h01 && cfg_ff[4] == 8'h01 &&
                    cfg_ff[6] == 8'h05 && cfg_ff[7] == 8'h04))
    else $error("Standby reset values are wrong.");

  main_reset_vals_a: assert property (
    @(posedge core_clk) disable iff (rst)
    main_rst |=> (cfg_ff[4] == 8'h00 && cfg_ff[5] == 8'h00 &&
                  cfg_ff[0] == $past(cfg_ff[0])))
    else $error("Main reset did not clear pins 3.2 and 3.3.");

  main_reset_tx_a: assert property (
    @(posedge core_clk) disable iff (rst)
    main_rst |=> cfg_ff[7] == 8'h04)
    else $error("Main reset did not load pin 3.5 value.");

  input_no_drive_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && cfg_ff[3][0] && !cfg_ff[3][2]) |=> !pad_oe[3])
    else $error("Input pin is still driven.");

  polarity_read_a: assert property (
    @(posedge core_clk) disable iff (rst)
    clk_en |=> gpio_in_value[5] == ($past(pad_in[5]) ^ $past(cfg_ff[5][1])))
    else $error("Read value ignores polarity.");

  open_drain_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && cfg_ff[0][7]) |=> !pad_out[0])
    else $error("Open drain pin drives high.");

  smi_route_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && cfg_ff[1][2] && !cfg_ff[1][7])
      |=> (pad_oe[1] && pad_out[1] == $past(system_mgmt_interrupt_out_n)))
    else $error("Interrupt output not routed to pin 2.7.");

  tach_b_route_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && cfg_ff[2][2]) |=> fan_speed_sense_b == $past(pad_in[2]))
    else $error("Second speed sense not taken from pin 3.0.");

  tach_a_route_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && !cfg_ff[3][2]) |=> !fan_speed_sense_a)
    else $error("First speed sense active while pin 3.1 is GPIO.");

  fan_route_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && cfg_ff[4][2] && !cfg_ff[4][7])
      |=> pad_out[4] == $past(fan_drive_b))
    else $error("Fan drive not routed to pin 3.2.");

  plain_gpio_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && !cfg_ff[5][0] && !cfg_ff[5][7])
      |=> pad_oe[5] && pad_out[5] == ($past(gpio_out_value[5]) ^ $past(cfg_ff[5][1])))
    else $error("Pin 3.3 does not act as GPIO output.");

  ir_rx_route_a: assert property (
    @(posedge core_clk) disable iff (rst)
    (clk_en && cfg_ff[6][2]) |=> (!pad_oe[6] && infrared_receive_b == $past(pad_in[6])))
    else $error("Infrared receive not taken from pin 3.4.");

  write_answer_a: assert property (
    @(posedge core_clk) disable iff (rst)
    wr_fire |=> (s_axi_bvalid &&
                 s_axi_bresp == ($past(wr_mapped) ? gpb_pkg::RESP_OKAY : gpb_pkg::RESP_SLVERR)))
    else $error("Write response missing or wrong.");

endmodule

// [gpb_pkg.sv]
// Constants shared by the pin configuration bank and its pin cells.
package gpb_pkg;

  // ---------------------------------------------------------------------
  // Bank size and register indices
  // ---------------------------------------------------------------------
  localparam int         NUM_PINS        = 8;
  localparam int         ADDR_W          = 10;
  localparam int         IDX_W           = 8;
  localparam int         IDX_LSB         = 2;
  localparam logic [7:0] IDX_PIN_2_6     = 8'h31;
  localparam logic [7:0] IDX_PIN_2_7     = 8'h32;
  localparam logic [7:0] IDX_PIN_3_0     = 8'h33;
  localparam logic [7:0] IDX_PIN_3_1     = 8'h34;
  localparam logic [7:0] IDX_PIN_3_2     = 8'h35;
  localparam logic [7:0] IDX_PIN_3_3     = 8'h36;
  localparam logic [7:0] IDX_PIN_3_4     = 8'h37;
  localparam logic [7:0] IDX_PIN_3_5     = 8'h38;
  localparam logic [7:0] IDX_FIRST       = IDX_PIN_2_6;
  localparam logic [7:0] IDX_LAST        = IDX_PIN_3_5;

  // ---------------------------------------------------------------------
  // Field layout of every configuration register
  // ---------------------------------------------------------------------
  localparam int         BIT_DIR         = 0;
  localparam int         BIT_POL         = 1;
  localparam int         BIT_ALT         = 2;
  localparam int         BIT_OD          = 7;
  localparam logic [7:0] CFG_WRITE_MASK  = 8'h87;

  // ---------------------------------------------------------------------
  // Reset values, pin 2.6 in the lowest byte
  // ---------------------------------------------------------------------
  localparam logic [NUM_PINS-1:0][7:0] STBY_RST_VAL =
    {8'h04, 8'h05, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
  localparam logic [NUM_PINS-1:0][7:0] MAIN_RST_VAL =
    {8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [NUM_PINS-1:0]      MAIN_RST_HIT = 8'hB0;

  // ---------------------------------------------------------------------
  // Alternate function kinds, pin 2.6 in the lowest slot
  // ---------------------------------------------------------------------
  localparam logic [1:0] ALT_NONE        = 2'h0;
  localparam logic [1:0] ALT_OUT         = 2'h1;
  localparam logic [1:0] ALT_IN          = 2'h2;
  localparam logic [NUM_PINS-1:0][1:0] ALT_KIND =
    {ALT_OUT, ALT_IN, ALT_NONE, ALT_OUT, ALT_IN, ALT_IN, ALT_OUT, ALT_OUT};

  // ---------------------------------------------------------------------
  // Bus answers
  // ---------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;

endpackage

// [gpb_pin_cell.sv]
// One pad cell: direction, polarity, driver type and alternate function routing.
`timescale 1ns/1ps
module gpb_pin_cell #(
  parameter logic [1:0] ALT_KIND = gpb_pkg::ALT_NONE
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic [7:0] cfg,
  input  wire logic       gpio_value,
  input  wire logic       alt_value,
  input  wire logic       pad_in,
  output logic            pad_out,
  output logic            pad_oe,
  output logic            gpio_in,
  output logic            alt_in
);

  logic alt_sel;
  logic nxt_drive_en;
  logic nxt_drive_val;

  // A pin without an alternate function keeps the stored bit but stays GPIO.
  assign alt_sel = cfg[gpb_pkg::BIT_ALT] && (ALT_KIND != gpb_pkg::ALT_NONE);

  always_comb begin
    if (alt_sel) begin
      nxt_drive_en  = (ALT_KIND == gpb_pkg::ALT_OUT);
      nxt_drive_val = alt_value;
    end else begin
      nxt_drive_en  = !cfg[gpb_pkg::BIT_DIR];
      nxt_drive_val = gpio_value ^ cfg[gpb_pkg::BIT_POL];
    end
  end

  // Open drain only ever pulls low, so a high level releases the pad.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pad_oe  <= 1'b0;
      pad_out <= 1'b0;
    end else if (clk_en) begin
      pad_oe  <= nxt_drive_en && (!cfg[gpb_pkg::BIT_OD] || !nxt_drive_val);
      pad_out <= nxt_drive_val && !cfg[gpb_pkg::BIT_OD];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      gpio_in <= 1'b0;
      alt_in  <= 1'b0;
    end else if (clk_en) begin
      gpio_in <= pad_in ^ cfg[gpb_pkg::BIT_POL];
      alt_in  <= alt_sel && (ALT_KIND == gpb_pkg::ALT_IN) && pad_in;
    end
  end

endmodule

// [gpio_pin_config_bank_bench.sv]
// Self-checking testbench for the pin configuration bank.
`timescale 1ns/1ps
module gpio_pin_config_bank_bench;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic        core_clk;
  logic        rst;
  logic        main_rst;
  logic        clk_en;
  logic [9:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [9:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic [7:0]  pad_in;
  logic [7:0]  pad_out;
  logic [7:0]  pad_oe;
  logic [7:0]  gpio_out_value;
  logic [7:0]  gpio_in_value;
  logic        music_serial_output;
  logic        system_mgmt_interrupt_out_n;
  logic        fan_drive_b;
  logic        infrared_transmit_b;
  logic        fan_speed_sense_a;
  logic        fan_speed_sense_b;
  logic        infrared_receive_b;
  logic [7:0]  cfg_m [8];
  int          mismatches;
  int          samples_checked;
  int          seed;
  int          bad_addr [4] = '{32'h0, 32'hC0, 32'hE4, 32'h3FC};

  gpb_bank uut (.core_clk(core_clk), .rst(rst), .main_rst(main_rst), .clk_en(clk_en),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .gpio_out_value(gpio_out_value),
    .gpio_in_value(gpio_in_value), .music_serial_output(music_serial_output),
    .system_mgmt_interrupt_out_n(system_mgmt_interrupt_out_n), .fan_drive_b(fan_drive_b),
    .infrared_transmit_b(infrared_transmit_b), .fan_speed_sense_a(fan_speed_sense_a),
    .fan_speed_sense_b(fan_speed_sense_b), .infrared_receive_b(infrared_receive_b));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ------------------------------------------------------------------
  // Expectations
  // ------------------------------------------------------------------
  function automatic logic [7:0] stby_val(input int i);
    if (i == 6) return 8'h05;
    if (i == 7) return 8'h04;
    return 8'h01;
  endfunction

  function automatic logic [9:0] addr_of(input int i);
    return 10'((32'h31 + i) * 4);
  endfunction

  function automatic logic alt_val(input int i);
    case (i)
      0: return music_serial_output;
      1: return system_mgmt_interrupt_out_n;
      4: return fan_drive_b;
      7: return infrared_transmit_b;
      default: return 1'b0;
    endcase
  endfunction

  // Returns {output enable, driven level}; alternate inputs switch the driver off.
  function automatic logic [1:0] pad_exp(input int i, input logic [7:0] c, input logic gv);
    logic alt_o;
    logic v;
    alt_o = c[2] && (i == 0 || i == 1 || i == 4 || i == 7);
    if (c[2] && (i == 2 || i == 3 || i == 6)) return 2'h0;
    v = alt_o ? alt_val(i) : gv ^ c[1];
    if (!alt_o && c[0]) return 2'h0;
    if (c[7]) return {!v, 1'b0};
    return {1'b1, v};
  endfunction

  // ------------------------------------------------------------------
  // Compare and bus tasks
  // ------------------------------------------------------------------
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_pin(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected pin level at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(inout int n);
    @(posedge core_clk);
    n++;
    if (n > 50) begin
      mismatches++;
      $display("bus wait limit reached at %0t", $time);
      results();
    end
  endtask

  task automatic axi_write(input int i, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] resp);
    int   n;
    logic aw_ok;
    logic w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr  <= (i < 0) ? 10'(-i - 1) : addr_of(i);
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    forever begin
      tick(n);
      if (!aw_ok && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      if (aw_ok && w_ok && s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  // A negative index n stands for the raw byte address -n-1, so address zero fits too.
  task automatic axi_read(input int i, output logic [31:0] d, output logic [1:0] resp);
    int   n;
    logic ar_ok;
    n = 0;
    ar_ok = 1'b0;
    @(posedge core_clk);
    s_axi_araddr  <= (i < 0) ? 10'(-i - 1) : addr_of(i);
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    forever begin
      tick(n);
      if (!ar_ok && s_axi_arready) begin
        ar_ok = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
      if (ar_ok && s_axi_rvalid) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic read_all;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++) begin
      axi_read(i, d, r);
      check_resp(r, gpb_pkg::RESP_OKAY);
      check_word(d, {24'h0, cfg_m[i]});
    end
  endtask

  task automatic check_pads;
    logic [1:0] e;
    for (int i = 0; i < 8; i++) begin
      e = pad_exp(i, cfg_m[i], gpio_out_value[i]);
      check_pin(pad_oe[i], e[1]);
      if (e[1]) check_pin(pad_out[i], e[0]);
      check_pin(gpio_in_value[i], pad_in[i] ^ cfg_m[i][1]);
    end
    check_pin(fan_speed_sense_b, cfg_m[2][2] & pad_in[2]);
    check_pin(fan_speed_sense_a, cfg_m[3][2] & pad_in[3]);
    check_pin(infrared_receive_b, cfg_m[6][2] & pad_in[6]);
  endtask

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          i;
    {main_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {pad_in, gpio_out_value, music_serial_output, system_mgmt_interrupt_out_n} = '0;
    {fan_drive_b, infrared_transmit_b} = '0;
    clk_en = 1'b1;
    rst = 1'b1;
    seed = 41;
    mismatches = 0;
    samples_checked = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) cfg_m[k] = stby_val(k);
    read_all();
    $display("test reset_values done");

    for (int k = 0; k < 8; k++) begin
      d = (k == 0) ? 32'hFFFF_FFFF : $random(seed);
      axi_write(k, d, 4'hF, r);
      check_resp(r, gpb_pkg::RESP_OKAY);
      cfg_m[k] = d[7:0] & 8'h87;
      axi_write(k, ~d, 4'hE, r);
      check_resp(r, gpb_pkg::RESP_OKAY);
    end
    read_all();
    $display("test write_readback done");

    foreach (bad_addr[j]) begin
      i = -bad_addr[j] - 1;
      axi_write(i, 32'h0000_0087, 4'hF, r);
      check_resp(r, gpb_pkg::RESP_SLVERR);
      axi_read(i, d, r);
      check_resp(r, gpb_pkg::RESP_SLVERR);
      check_word(d, 32'h0);
    end
    read_all();
    $display("test unmapped done");

    // The first sweep selects every alternate function with open-drain drivers.
    for (int k = 0; k < 48; k++) begin
      i = (k < 8) ? k : int'($unsigned($random(seed)) % 8);
      d = (k < 8) ? 32'h84 : $random(seed);
      axi_write(i, d, 4'h1, r);
      check_resp(r, gpb_pkg::RESP_OKAY);
      cfg_m[i] = d[7:0] & 8'h87;
      gpio_out_value <= 8'($random(seed));
      pad_in <= 8'($random(seed));
      {music_serial_output, system_mgmt_interrupt_out_n} <= 2'($random(seed));
      {fan_drive_b, infrared_transmit_b} <= 2'($random(seed));
      repeat (3) @(posedge core_clk);
      check_pads();
    end
    $display("test pad_routing done");

    @(posedge core_clk);
    main_rst <= 1'b1;
    @(posedge core_clk);
    main_rst <= 1'b0;
    cfg_m[4] = 8'h00;
    cfg_m[5] = 8'h00;
    cfg_m[7] = 8'h04;
    read_all();
    $display("test main_reset done");

    axi_write(0, 32'h0, 4'hF, r);
    cfg_m[0] = 8'h00;
    gpio_out_value <= 8'h00;
    repeat (3) @(posedge core_clk);
    check_pin(pad_out[0], 1'b0);
    clk_en <= 1'b0;
    gpio_out_value <= 8'h01;
    repeat (3) @(posedge core_clk);
    check_pin(pad_out[0], 1'b0);
    clk_en <= 1'b1;
    repeat (3) @(posedge core_clk);
    check_pin(pad_out[0], 1'b1);
    $display("test clock_enable done");

    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    for (int k = 0; k < 8; k++) cfg_m[k] = stby_val(k);
    read_all();
    $display("test second_reset done");
    results();
  end

endmodule
